// *** design/irq_ctrl.sv ***
// Purpose: interrupt controller: flags, enables, four levels, forced call
// Assumes: sources and core strobes come from logic on the same clock
// Notes:   one machine cycle per clock; serial flags live in the serial units
//
// Contract
// - eleven sources, four priority levels
// - preempt only by strictly higher level
// - return ends current service level
// - flags set regardless of enables
// - sample flags each cycle, then poll
// - forced call to vector if allowed
// - hold off on return or config writes
// - seven cycles: detect plus six call
// - global enable bit gates everything
// - main enable register source bits
// - ext-high enable bits for ext2..ext6
// - serial b enable bit
// - timer and pin control layout
// - ext2..ext6 edge flags layout
// - timer flags cleared, acknowledge on entry
// - ext0/ext1 auto cleared in edge mode, ext2..ext5 always, ext6 manual
// - ext2 and ext3 polarity programmable
// - ext4..ext6 rising in core, inversions
// - ext6 from tick or transfer flags
// - ext0/ext1 from digital io requests
// - type bit: edge when set, level else
// - six groups, two priority bits each
// - fixed polling order breaks ties
// - fixed vector address per source
//
// The address map and the Avalon-MM register port were decided locally.
`timescale 1ns/10ps
module irq_ctrl
    import irq_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // avalon-mm slave
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [3:0]  byteenable,
    input  wire logic [31:0] writedata,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    // interrupt sources
    input  wire logic        timer_a_overflow,
    input  wire logic        timer_b_overflow,
    input  wire logic        serial_a_req,
    input  wire logic        serial_b_req,
    input  wire logic        dio_hi_req_n,
    input  wire logic        dio_lo_req_n,
    input  wire logic        comparator_edge_event,
    input  wire logic        ce_busy,
    input  wire logic        comparator_rise_event,
    input  wire logic        eeprom_busy,
    input  wire logic        one_second_tick,
    input  wire logic        transfer_busy_request,
    // instruction sequencer
    input  wire logic        insn_is_return_from_interrupt,
    input  wire logic        insn_writes_irq_cfg,
    output logic             forced_long_call,
    output logic [15:0]      call_vector,
    output logic             service_entered,
    output logic [3:0]       active_levels,
    // timer side
    output logic             timer_a_service_ack,
    output logic             timer_b_service_ack,
    output logic             timer_a_run,
    output logic             timer_b_run
);

    typedef struct packed {
        logic [7:0]  ien_main;
        logic [7:0]  ien_hi;
        logic [7:0]  ien_ser_b;
        logic [7:0]  timer_and_pin_irq_ctrl;
        logic [7:0]  ext_flags;
        logic [7:0]  prio_low;
        logic [7:0]  prio_high;
        logic [7:0]  aux;
        logic [10:0] samp;
        logic [6:0]  prev_in;
        ctrl_state_e state;
        logic [2:0]  cnt;
        logic [3:0]  sel_idx;
        logic [1:0]  sel_lvl;
        logic [3:0]  active;
        logic [15:0] vector;
        logic        call;
        logic        entered;
        logic        ack_a;
        logic        ack_b;
        logic        bus_ack;
        logic [31:0] rdata;
    } ctrl_s;

    ctrl_s s_q;
    ctrl_s s_d;

    function automatic logic [6:0] pick_best(input logic [10:0] pend,
                                             input logic [7:0]  plow,
                                             input logic [7:0]  phigh);
        logic        found;
        logic [3:0]  idx;
        logic [1:0]  lvl;
        logic [1:0]  cand;
        found = 1'b0;
        idx   = 4'h0;
        lvl   = 2'h0;
        // strict compare keeps the earlier polled source on a tie
        for (int i = 0; i < NUM_SRC; i++)
        begin
            cand = {phigh[SRC_GROUP[i]], plow[SRC_GROUP[i]]};
            if (pend[i] && (!found || cand > lvl))
            begin
                found = 1'b1;
                idx   = 4'(i);
                lvl   = cand;
            end
        end
        return {found, idx, lvl};
    endfunction

    function automatic logic [2:0] top_level(input logic [3:0] act);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 0; i < NUM_LEVELS; i++)
        begin
            if (act[i])
            begin
                r = {1'b1, 2'(i)};
            end
        end
        return r;
    endfunction

    logic        req;
    logic        wr;
    logic [7:0]  wd;
    logic [6:0]  cur_in;
    logic [6:0]  rise;
    logic [10:0] flags;
    logic [10:0] enables;
    logic [10:0] pend;
    logic [6:0]  best;
    logic [2:0]  top;
    logic        blocked;
    logic        take;
    logic        ext6_src;
    logic        call_end;

    always_comb
    begin
        s_d      = s_q;
        req      = read | write;
        wr       = write & s_q.bus_ack & byteenable[0];
        wd       = writedata[7:0];
        s_d.bus_ack = req & ~s_q.bus_ack;
        // ext6 core input from enabled tick/transfer flags
        ext6_src = (s_q.aux[TICK_FLAG_BIT] & s_q.aux[TICK_EN_BIT]) |
                   (s_q.aux[XFER_FLAG_BIT] & s_q.aux[XFER_EN_BIT]);
        // digital io requests, active low; selectable polarity
        cur_in   = {ext6_src,
                    ~eeprom_busy,
                    comparator_rise_event,
                    s_q.aux[EXT3_RISE_BIT] ? ce_busy : ~ce_busy,
                    s_q.aux[EXT2_RISE_BIT] ? comparator_edge_event : ~comparator_edge_event,
                    ~dio_lo_req_n,
                    ~dio_hi_req_n};
        rise     = cur_in & ~s_q.prev_in;
        s_d.prev_in = cur_in;
        flags    = {s_q.ext_flags[EXT2_FLAG_BIT+4], s_q.ext_flags[EXT2_FLAG_BIT+3], serial_a_req,
                    s_q.ext_flags[EXT2_FLAG_BIT+2], s_q.timer_and_pin_irq_ctrl[TMR_B_FLAG_BIT], s_q.ext_flags[EXT2_FLAG_BIT+1],
                    s_q.timer_and_pin_irq_ctrl[EXT1_FLAG_BIT], s_q.ext_flags[EXT2_FLAG_BIT], s_q.timer_and_pin_irq_ctrl[TMR_A_FLAG_BIT],
                    serial_b_req, s_q.timer_and_pin_irq_ctrl[EXT0_FLAG_BIT]};
        enables  = {s_q.ien_hi[EXT2_EN_BIT+4], s_q.ien_hi[EXT2_EN_BIT+3], s_q.ien_main[SER_A_EN_BIT],
                    s_q.ien_hi[EXT2_EN_BIT+2], s_q.ien_main[TMR_B_EN_BIT], s_q.ien_hi[EXT2_EN_BIT+1],
                    s_q.ien_main[EXT1_EN_BIT], s_q.ien_hi[EXT2_EN_BIT], s_q.ien_main[TMR_A_EN_BIT],
                    s_q.ien_ser_b[SER_B_EN_BIT], s_q.ien_main[EXT0_EN_BIT]};
        pend     = (flags & enables) & {NUM_SRC{s_q.ien_main[GLOBAL_EN_BIT]}};
        // sampled once per machine cycle, polled next
        s_d.samp = pend;
        best     = pick_best(s_q.samp, s_q.prio_low, s_q.prio_high);
        top      = top_level(s_q.active);
        // hold off during return or enable/priority writes
        blocked  = insn_is_return_from_interrupt | insn_writes_irq_cfg |
                   (write & (address == REG_IEN_MAIN || address == REG_IEN_EXT_HI ||
                             address == REG_IEN_SER_B || address == REG_PRIO_LOW ||
                             address == REG_PRIO_HIGH));
        // strictly above the highest level in service
        take     = best[6] && !blocked && (!top[2] || best[1:0] > top[1:0]);
        call_end = (s_q.state == ST_CALL) && (s_q.cnt == 3'h0);
        s_d.entered = 1'b0;
        s_d.ack_a   = 1'b0;
        s_d.ack_b   = 1'b0;
        // return drops the highest active level
        if (insn_is_return_from_interrupt && top[2])
        begin
            s_d.active[top[1:0]] = 1'b0;
        end
        case (s_q.state)
            ST_IDLE:
            begin
                // start six-cycle call to the vector
                if (take)
                begin
                    s_d.state   = ST_CALL;
                    s_d.cnt     = CALL_LAST;
                    s_d.sel_idx = best[5:2];
                    s_d.sel_lvl = best[1:0];
                    s_d.vector  = SRC_VECTOR[best[5:2]];
                    s_d.call    = 1'b1;
                end
            end
            ST_CALL:
            begin
                if (call_end)
                begin
                    s_d.state   = ST_IDLE;
                    s_d.call    = 1'b0;
                    s_d.entered = 1'b1;
                    s_d.active[s_q.sel_lvl] = 1'b1;
                    s_d.ack_a   = (s_q.sel_idx == SRC_TMR_A);
                    s_d.ack_b   = (s_q.sel_idx == SRC_TMR_B);
                end
                else
                begin
                    s_d.cnt = s_q.cnt - 3'h1;
                end
            end
            default:
            begin
                s_d.state = ST_IDLE;
                s_d.call  = 1'b0;
            end
        endcase
        // software writes land first
        if (wr && address == REG_IEN_MAIN)   s_d.ien_main  = wd;
        if (wr && address == REG_IEN_EXT_HI) s_d.ien_hi    = wd & IEN_HI_MASK;
        if (wr && address == REG_IEN_SER_B)  s_d.ien_ser_b = wd;
        if (wr && address == REG_TIMER_AND_PIN_IRQ_CTRL)       s_d.timer_and_pin_irq_ctrl      = wd;
        if (wr && address == REG_EXT_FLAGS)  s_d.ext_flags = wd & EXT_FLAGS_MASK;
        if (wr && address == REG_PRIO_LOW)   s_d.prio_low  = wd;
        if (wr && address == REG_PRIO_HIGH)  s_d.prio_high = wd;
        // software clears tick and transfer flags here
        if (wr && address == REG_AUX)        s_d.aux       = {2'h0, wd[5:0]};
        // hardware clear on vectoring, ext6 left to software
        if (call_end && AUTO_CLEAR[s_q.sel_idx])
        begin
            case (s_q.sel_idx)
                SRC_EXT0:  s_d.timer_and_pin_irq_ctrl[EXT0_FLAG_BIT] = ~s_q.timer_and_pin_irq_ctrl[EXT0_TYPE_BIT] & s_d.timer_and_pin_irq_ctrl[EXT0_FLAG_BIT];
                SRC_TMR_A: s_d.timer_and_pin_irq_ctrl[TMR_A_FLAG_BIT] = 1'b0;
                SRC_EXT1:  s_d.timer_and_pin_irq_ctrl[EXT1_FLAG_BIT] = ~s_q.timer_and_pin_irq_ctrl[EXT1_TYPE_BIT] & s_d.timer_and_pin_irq_ctrl[EXT1_FLAG_BIT];
                SRC_TMR_B: s_d.timer_and_pin_irq_ctrl[TMR_B_FLAG_BIT] = 1'b0;
                SRC_EXT2:  s_d.ext_flags[EXT2_FLAG_BIT] = 1'b0;
                SRC_EXT3:  s_d.ext_flags[EXT2_FLAG_BIT+1] = 1'b0;
                SRC_EXT4:  s_d.ext_flags[EXT2_FLAG_BIT+2] = 1'b0;
                SRC_EXT5:  s_d.ext_flags[EXT2_FLAG_BIT+3] = 1'b0;
                default:   s_d.timer_and_pin_irq_ctrl = s_d.timer_and_pin_irq_ctrl;
            endcase
        end
        // hardware sets applied last so they win
        if (timer_a_overflow) s_d.timer_and_pin_irq_ctrl[TMR_A_FLAG_BIT] = 1'b1;
        if (timer_b_overflow) s_d.timer_and_pin_irq_ctrl[TMR_B_FLAG_BIT] = 1'b1;
        // edge mode sets, level mode follows the line
        if (s_q.timer_and_pin_irq_ctrl[EXT0_TYPE_BIT])
        begin
            if (rise[0]) s_d.timer_and_pin_irq_ctrl[EXT0_FLAG_BIT] = 1'b1;
        end
        else
        begin
            s_d.timer_and_pin_irq_ctrl[EXT0_FLAG_BIT] = cur_in[0];
        end
        if (s_q.timer_and_pin_irq_ctrl[EXT1_TYPE_BIT])
        begin
            if (rise[1]) s_d.timer_and_pin_irq_ctrl[EXT1_FLAG_BIT] = 1'b1;
        end
        else
        begin
            s_d.timer_and_pin_irq_ctrl[EXT1_FLAG_BIT] = cur_in[1];
        end
        for (int k = 0; k < 5; k++)
        begin
            if (rise[k+2]) s_d.ext_flags[EXT2_FLAG_BIT+k] = 1'b1;
        end
        if (one_second_tick)       s_d.aux[TICK_FLAG_BIT] = 1'b1;
        if (transfer_busy_request) s_d.aux[XFER_FLAG_BIT] = 1'b1;
        // read data captured in the wait cycle, unmapped reads zero
        s_d.rdata = 32'h0;
        if (read && !s_q.bus_ack)
        begin
            case (address)
                REG_IEN_MAIN:   s_d.rdata = {24'h0, s_q.ien_main};
                REG_IEN_EXT_HI: s_d.rdata = {24'h0, s_q.ien_hi};
                REG_IEN_SER_B:  s_d.rdata = {24'h0, s_q.ien_ser_b};
                REG_TIMER_AND_PIN_IRQ_CTRL:       s_d.rdata = {24'h0, s_q.timer_and_pin_irq_ctrl};
                REG_EXT_FLAGS:  s_d.rdata = {24'h0, s_q.ext_flags};
                REG_PRIO_LOW:   s_d.rdata = {24'h0, s_q.prio_low};
                REG_PRIO_HIGH:  s_d.rdata = {24'h0, s_q.prio_high};
                REG_AUX:        s_d.rdata = {24'h0, s_q.aux};
                REG_STATUS:     s_d.rdata = {23'h0, s_q.sel_idx, s_q.call, s_q.active};
                default:        s_d.rdata = 32'h0;
            endcase
        end
        else if (s_q.bus_ack)
        begin
            s_d.rdata = s_q.rdata;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            s_q <= '{ien_main: RESET_BYTE, ien_hi: RESET_BYTE, ien_ser_b: RESET_BYTE, timer_and_pin_irq_ctrl: RESET_BYTE,
                     ext_flags: RESET_BYTE, prio_low: RESET_BYTE, prio_high: RESET_BYTE, aux: RESET_BYTE,
                     samp: 11'h0, prev_in: EDGE_IDLE, state: ST_IDLE, cnt: 3'h0, sel_idx: 4'h0, sel_lvl: 2'h0,
                     active: 4'h0, vector: 16'h0, call: 1'b0, entered: 1'b0, ack_a: 1'b0, ack_b: 1'b0,
                     bus_ack: 1'b0, rdata: 32'h0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign readdata            = s_q.rdata;
    assign waitrequest         = ~s_q.bus_ack;
    assign forced_long_call    = s_q.call;
    assign call_vector         = s_q.vector;
    assign service_entered     = s_q.entered;
    assign active_levels       = s_q.active;
    assign timer_a_service_ack = s_q.ack_a;
    assign timer_b_service_ack = s_q.ack_b;
    assign timer_a_run         = s_q.timer_and_pin_irq_ctrl[4];
    assign timer_b_run         = s_q.timer_and_pin_irq_ctrl[6];

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_call_len;
        $rose(forced_long_call) |-> forced_long_call [*6] ##1 !forced_long_call;
    endproperty
    a_call_len: assert property (p_call_len) else $error("forced call not six cycles");
    property p_entry;
        $rose(forced_long_call) |-> ##6 service_entered;
    endproperty
    a_entry: assert property (p_entry) else $error("entry not six cycles after call");
    property p_global;
        $rose(forced_long_call) |-> $past(s_q.ien_main[GLOBAL_EN_BIT], 2);
    endproperty
    a_global: assert property (p_global) else $error("call taken with global enable off");
    property p_hold_off;
        $rose(forced_long_call) |-> !$past(insn_is_return_from_interrupt) && !$past(insn_writes_irq_cfg);
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("call during return or cfg write");
    property p_preempt;
        $rose(forced_long_call) |-> !$past(top[2]) || s_q.sel_lvl > $past(top[1:0]);
    endproperty
    a_preempt: assert property (p_preempt) else $error("preempted by equal or lower level");
    property p_return_from_interrupt;
        insn_is_return_from_interrupt && top[2] && !call_end |=> $countones(s_q.active) == $countones($past(s_q.active)) - 1;
    endproperty
    a_return_from_interrupt: assert property (p_return_from_interrupt) else $error("return did not end a level");
    property p_timer_ack;
        timer_a_service_ack |-> service_entered && !(s_q.timer_and_pin_irq_ctrl[TMR_A_FLAG_BIT] && !$past(timer_a_overflow));
    endproperty
    a_timer_ack: assert property (p_timer_ack) else $error("timer a ack without entry or flag clear");
    property p_set_wins;
        timer_b_overflow |=> s_q.timer_and_pin_irq_ctrl[TMR_B_FLAG_BIT];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("timer b overflow flag lost");
    property p_ext6_manual;
        service_entered && s_q.sel_idx == SRC_EXT6 |-> s_q.ext_flags[EXT2_FLAG_BIT+4] || $past(wr);
    endproperty
    a_ext6_manual: assert property (p_ext6_manual) else $error("ext6 flag cleared by hardware");
    property p_bus;
        req && waitrequest |=> !waitrequest;
    endproperty
    a_bus: assert property (p_bus) else $error("waitrequest held more than one cycle");

    c_call:    cover property ($rose(forced_long_call));
    c_preempt: cover property ($rose(forced_long_call) && s_q.active != 4'h0);
    c_return_from_interrupt:    cover property (insn_is_return_from_interrupt && top[2]);
    c_top:     cover property (service_entered && s_q.sel_lvl == 2'h3);

endmodule

// *** include/irq_ctrl_pkg.sv ***
// Purpose: shared constants and types for the core interrupt controller
// Assumes: one machine cycle per clock at 10 MHz
// Notes:   source index is the fixed polling position, 0 polled first
package irq_ctrl_pkg;

    localparam int          CLOCK_HZ        = 10_000_000;
    localparam int          NUM_SRC         = 11;
    localparam int          NUM_LEVELS      = 4;
    // latency in machine cycles: detect plus forced call
    localparam int          DETECT_MCYC     = 1;
    localparam int          CALL_MCYC       = 6;
    localparam int          LATENCY_MCYC    = DETECT_MCYC + CALL_MCYC;
    localparam logic [2:0]  CALL_LAST       = 3'(CALL_MCYC - 1);

    // register word indices, byte address is four times the index
    localparam logic [3:0]  REG_IEN_MAIN    = 4'h0;
    localparam logic [3:0]  REG_IEN_EXT_HI  = 4'h1;
    localparam logic [3:0]  REG_IEN_SER_B   = 4'h2;
    localparam logic [3:0]  REG_TIMER_AND_PIN_IRQ_CTRL        = 4'h3;
    localparam logic [3:0]  REG_EXT_FLAGS   = 4'h4;
    localparam logic [3:0]  REG_PRIO_LOW    = 4'h5;
    localparam logic [3:0]  REG_PRIO_HIGH   = 4'h6;
    localparam logic [3:0]  REG_AUX         = 4'h7;
    localparam logic [3:0]  REG_STATUS      = 4'h8;

    // irq_enable_main fields
    localparam int          GLOBAL_EN_BIT   = 7;
    localparam int          SER_A_EN_BIT    = 4;
    localparam int          TMR_B_EN_BIT    = 3;
    localparam int          EXT1_EN_BIT     = 2;
    localparam int          TMR_A_EN_BIT    = 1;
    localparam int          EXT0_EN_BIT     = 0;
    // irq_enable_ext_hi: ext2..ext6 enables from this bit up
    localparam int          EXT2_EN_BIT     = 1;
    localparam int          SER_B_EN_BIT    = 0;
    // timer_and_pin_irq_ctrl fields
    localparam int          TMR_B_FLAG_BIT  = 7;
    localparam int          TMR_A_FLAG_BIT  = 5;
    localparam int          EXT1_FLAG_BIT   = 3;
    localparam int          EXT1_TYPE_BIT   = 2;
    localparam int          EXT0_FLAG_BIT   = 1;
    localparam int          EXT0_TYPE_BIT   = 0;
    // ext_irq_request_flags: ext2..ext6 flags from this bit up
    localparam int          EXT2_FLAG_BIT   = 1;
    localparam logic [7:0]  EXT_FLAGS_MASK  = 8'h3e;
    localparam logic [7:0]  IEN_HI_MASK     = 8'h7e;
    // aux register fields
    localparam int          TICK_EN_BIT     = 0;
    localparam int          XFER_EN_BIT     = 1;
    localparam int          EXT2_RISE_BIT   = 2;
    localparam int          EXT3_RISE_BIT   = 3;
    localparam int          TICK_FLAG_BIT   = 4;
    localparam int          XFER_FLAG_BIT   = 5;
    localparam logic [7:0]  RESET_BYTE      = 8'h00;
    // edge history at the lines' rest levels, so leaving reset is no edge
    localparam logic [6:0]  EDGE_IDLE       = 7'h2c;

    // polling positions
    localparam logic [3:0]  SRC_EXT0 = 4'h0, SRC_SER_B = 4'h1, SRC_TMR_A = 4'h2, SRC_EXT2 = 4'h3;
    localparam logic [3:0]  SRC_EXT1 = 4'h4, SRC_EXT3 = 4'h5, SRC_TMR_B = 4'h6, SRC_EXT4 = 4'h7;
    localparam logic [3:0]  SRC_SER_A = 4'h8, SRC_EXT5 = 4'h9, SRC_EXT6 = 4'ha;

    // priority group per polling position, position 10 first
    localparam logic [10:0][2:0] SRC_GROUP = {3'h5, 3'h4, 3'h4, 3'h3, 3'h3, 3'h2, 3'h2, 3'h1, 3'h1, 3'h0, 3'h0};
    localparam logic [10:0][15:0] SRC_VECTOR = {16'h006b, 16'h0063, 16'h0023, 16'h005b, 16'h001b, 16'h0053,
                                               16'h0013, 16'h004b, 16'h000b, 16'h0083, 16'h0003};
    // flags cleared by hardware on vectoring (ext0 and ext1 only in edge mode)
    localparam logic [10:0] AUTO_CLEAR = 11'h2fd;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CALL = 2'b10
    } ctrl_state_e;

endpackage

// *** test/core_seq_model.sv ***
// Purpose: stand-in for the instruction sequencer beside the controller
// Assumes: same clock as the controller
// Notes:   no return retires in the cycle after a forced call cycle; config writes pass through
`timescale 1ns/10ps
module core_seq_model
(
    // clock and reset
    input  wire logic clock,
    input  wire logic rst_n,
    // bench commands
    input  wire logic ret_cmd,
    input  wire logic cfg_cmd,
    // controller side
    input  wire logic forced_long_call,
    output logic      insn_is_return_from_interrupt,
    output logic      insn_writes_irq_cfg
);
    always_ff @(posedge clock)
    begin
        insn_is_return_from_interrupt        <= rst_n & ret_cmd & ~forced_long_call;
        insn_writes_irq_cfg <= rst_n & cfg_cmd;
    end
endmodule

// *** test/testbench.sv ***
// Purpose: register and vectoring checks of the interrupt controller
// Assumes: one wait cycle per bus access
// Notes:   src bit order follows the source ports
`timescale 1ns/10ps
module testbench;
    import irq_ctrl_pkg::*;
    logic        clock = 0, rst_n = 0, read = 0, write = 0, ret_cmd = 0, cfg_cmd = 0;
    logic [3:0]  address = 4'h0;
    logic [31:0] writedata = 32'h0, readdata, rd;
    logic [11:0] src = 12'h000;
    logic        waitrequest, flc, entered, ta_ack, tb_ack, return_from_interrupt, cfgw, ta_run, tb_run;
    logic [15:0] call_vector;
    logic [3:0]  active_levels;
    int          fail_count = 0, total_checks = 0;

    always #50 clock = ~clock;

    core_seq_model core (.clock(clock), .rst_n(rst_n), .ret_cmd(ret_cmd), .cfg_cmd(cfg_cmd),
        .forced_long_call(flc), .insn_is_return_from_interrupt(return_from_interrupt), .insn_writes_irq_cfg(cfgw));

    irq_ctrl dut (.clock(clock), .rst_n(rst_n), .address(address), .read(read), .write(write),
        .byteenable(4'h1), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .timer_a_overflow(src[0]), .timer_b_overflow(src[1]), .serial_a_req(src[2]),
        .serial_b_req(src[3]), .dio_hi_req_n(~src[4]), .dio_lo_req_n(~src[5]),
        .comparator_edge_event(src[6]), .ce_busy(src[7]), .comparator_rise_event(src[8]),
        .eeprom_busy(src[9]), .one_second_tick(src[10]), .transfer_busy_request(src[11]),
        .insn_is_return_from_interrupt(return_from_interrupt), .insn_writes_irq_cfg(cfgw), .forced_long_call(flc),
        .call_vector(call_vector), .service_entered(entered), .active_levels(active_levels),
        .timer_a_service_ack(ta_ack), .timer_b_service_ack(tb_ack), .timer_a_run(ta_run), .timer_b_run(tb_run));

    task check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    // request held until waitrequest is seen low
    task bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        int n;
        @(posedge clock);
        address <= a;
        write <= wr;
        read <= ~wr;
        writedata <= {24'h0, d};
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (waitrequest !== 1'b0 && n < 50);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        check(n < 50, 1);
    endtask

    task rd_chk(input logic [3:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        check(rd, {24'h0, exp});
    endtask

    task pulse(input logic [11:0] m);
        @(posedge clock);
        src <= m;
        @(posedge clock);
        src <= 12'h000;
    endtask

    task ret;
        @(posedge clock);
        ret_cmd <= 1'b1;
        @(posedge clock);
        ret_cmd <= 1'b0;
    endtask

    task no_call;
        logic seen;
        seen = 0;
        repeat (12)
        begin
            @(posedge clock);
            #1;
            seen |= (flc === 1'b1);
        end
        check(seen, 0);
    endtask

    // lat counts from the edge that raised the source, 0 skips it
    task call(input logic [15:0] v, input int lat);
        int n;
        int h;
        n = 1;
        h = 0;
        do
        begin
            @(posedge clock);
            #1;
            n++;
        end
        while (flc !== 1'b1 && n < 60);
        while (flc === 1'b1 && h < 20)
        begin
            h++;
            @(posedge clock);
            #1;
            n++;
        end
        check(h, CALL_MCYC);
        check(call_vector, v);
        check(entered, 1);
        check({ta_ack, tb_ack}, {v == 16'h000b, v == 16'h001b});
        if (lat > 0)
            check(n, lat);
    endtask

    task report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        #3000000;
        fail_count++;
        report_and_stop();
    end

    initial
    begin
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        for (int i = 0; i < 9; i++)
            rd_chk(4'(i), RESET_BYTE);
        rd_chk(4'hf, 8'h00);
        bus(1'b1, REG_TIMER_AND_PIN_IRQ_CTRL, 8'h50);
        rd_chk(REG_TIMER_AND_PIN_IRQ_CTRL, 8'h50);
        check({ta_run, tb_run}, 2'b11);
        bus(1'b1, REG_TIMER_AND_PIN_IRQ_CTRL, 8'h00);
        bus(1'b1, REG_IEN_EXT_HI, 8'hff);
        rd_chk(REG_IEN_EXT_HI, IEN_HI_MASK);
        bus(1'b1, REG_IEN_EXT_HI, 8'h00);
        bus(1'b1, REG_IEN_MAIN, 8'h0a);
        pulse(12'h001);
        no_call();
        rd_chk(REG_TIMER_AND_PIN_IRQ_CTRL, 8'h20);
        bus(1'b1, REG_IEN_MAIN, 8'h8a);
        call(16'h000b, 0);
        check(active_levels, 4'h1);
        rd_chk(REG_TIMER_AND_PIN_IRQ_CTRL, 8'h00);
        pulse(12'h002);
        no_call();
        ret();
        call(16'h001b, 0);
        ret();
        no_call();
        check(active_levels, 4'h0);
        pulse(12'h001);
        call(16'h000b, LATENCY_MCYC + 2);
        ret();
        pulse(12'h003);
        call(16'h000b, LATENCY_MCYC + 2);
        ret();
        call(16'h001b, 0);
        ret();
        no_call();
        bus(1'b1, REG_PRIO_HIGH, 8'h08);
        pulse(12'h001);
        call(16'h000b, 0);
        pulse(12'h002);
        call(16'h001b, 0);
        check(active_levels, 4'h5);
        ret();
        ret();
        no_call();
        @(posedge clock);
        cfg_cmd <= 1'b1;
        pulse(12'h001);
        no_call();
        @(posedge clock);
        cfg_cmd <= 1'b0;
        call(16'h000b, 0);
        ret();
        @(posedge clock);
        src <= 12'h008;
        no_call();
        bus(1'b1, REG_IEN_SER_B, 8'h01);
        call(16'h0083, 0);
        @(posedge clock);
        src <= 12'h000;
        ret();
        bus(1'b1, REG_TIMER_AND_PIN_IRQ_CTRL, 8'h01);
        bus(1'b1, REG_IEN_MAIN, 8'h8b);
        pulse(12'h010);
        call(16'h0003, LATENCY_MCYC + 2);
        rd_chk(REG_TIMER_AND_PIN_IRQ_CTRL, 8'h01);
        ret();
        bus(1'b1, REG_IEN_EXT_HI, 8'h02);
        pulse(12'h040);
        call(16'h004b, LATENCY_MCYC + 3);
        ret();
        bus(1'b1, REG_IEN_EXT_HI, 8'h28);
        pulse(12'h100);
        call(16'h005b, 0);
        rd_chk(REG_EXT_FLAGS, 8'h00);
        ret();
        no_call();
        bus(1'b1, REG_AUX, 8'h01);
        pulse(12'h400);
        call(16'h006b, 0);
        rd_chk(REG_EXT_FLAGS, 8'h20);
        rd_chk(REG_AUX, 8'h11);
        bus(1'b1, REG_EXT_FLAGS, 8'h00);
        bus(1'b1, REG_AUX, 8'h01);
        ret();
        no_call();
        report_and_stop();
    end
endmodule
